// ---- hw/mpd_phy.sv ----
// Transceiver end of the interface data path, with its receive buffer.
//
// What this block and the controller do
// RULE1 - Controller moves transmit nibble with transmit clock.
// RULE2 - Bit zero holds earliest serial bit.
// RULE3 - Transmit enable marks exactly the valid nibbles.
// RULE4 - Transceiver makes both clocks, 2.5/25 MHz.
// RULE5 - Receive nibble changes only with receive clock.
// RULE6 - Receive valid high exactly for valid nibbles.
// RULE7 - Controller flags transmit errors with transmit clock.
// RULE8 - Receive error raised in step with clock.
// RULE9 - Collision output held high while collision lasts.
// RULE10 - Collision stays low in full duplex.
// RULE11 - Half duplex: carrier on transmit or receive.
// RULE12 - Full duplex: carrier only on receive.
// RULE13 - Carrier rises anytime, falls with receive clock.
// RULE14 - Transmit group sampled at transmit clock rise.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Flip-flop FIFO with valid and ready on both sides.
module mpd_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Filling side.
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side.
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic rdy_q;
  logic empty_q;
  logic push;
  logic pop;

  // Handshakes complete only against the registered flags.
  assign push = i_in_valid & rdy_q;
  assign pop = i_out_ready & ~empty_q;
  assign o_in_ready = rdy_q; // Straight from a flop, not through an inverter.
  assign o_out_valid = ~empty_q;
  assign o_out_data = mem_q[rd_q];

  // One storage word per entry, written when the write pointer selects it.
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_ff @(posedge i_mclk) begin
      if (push && wr_q == AW'(e)) begin
        mem_q[e] <= i_in_data;
      end
    end
  end

  // Next fill level from this cycle's push and pop.
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  // Pointers, fill level and the flags derived from it.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != (AW+1)'(DEPTH));
      empty_q <= (cnt_d == '0);
    end
  end
endmodule : mpd_fifo

////////////////////////////////////////////////////////////////////////////////
// Transceiver end: makes the link clocks, takes transmit nibbles, sends receive
// nibbles and reports carrier and collision.
module mpd_phy (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Mode: link speed and the duplex control bit.
  input wire logic i_speed100,
  input wire logic i_full_duplex,
  // Line status from the receiver.
  input wire logic i_carrier,
  // Receive nibbles from the line decoder.
  input wire logic i_rx_valid,
  input wire logic [3:0] i_rx_nib,
  input wire logic i_rx_err,
  output logic o_rx_ready,
  // Transmit nibbles to the line encoder.
  output logic o_tx_valid,
  output logic [3:0] o_tx_nib,
  output logic o_tx_err,
  output logic o_tx_active,
  // Link to the controller.
  mpd_mii_if.phy mii
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [5:0] div_m1;
  logic [5:0] half;
  logic clk_q;
  logic rise;
  logic fall;
  logic q_valid;
  logic [mpd_pkg::RXQ_W-1:0] q_data;
  logic [3:0] rxd_q;
  logic rx_dv_q;
  logic rx_er_q;
  logic crs_q;
  logic col_q;
  logic want_crs;

  //////////////////////////////////////////////////////////////////////////////
  // Link clock divider.

  // Ratio picked by the speed; a change takes effect on the next system cycle, mid-count.
  assign div_m1 = i_speed100 ? mpd_pkg::DIV100_M1 : mpd_pkg::DIV10_M1; // RULE4
  assign half = i_speed100 ? mpd_pkg::HALF100 : mpd_pkg::HALF10;
  assign cnt_d = (cnt_q >= div_m1) ? mpd_pkg::CNT_RST : cnt_q + 6'h01;

  // Low for the first part of the count and high for the last half, so the
  // clock leaves reset with a full low phase instead of a runt high pulse.
  assign rise = (cnt_q == div_m1 - half);
  assign fall = (cnt_q >= div_m1);

  // One counter drives both link clocks, so they share phase and rate.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_q <= mpd_pkg::CNT_RST;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= (cnt_d > div_m1 - half); // RULE4
    end
  end

  assign mii.tx_clk = clk_q; // RULE4
  assign mii.rx_clk = clk_q; // RULE4

  //////////////////////////////////////////////////////////////////////////////
  // Transmit side.

  // The controller launches from the same system clock a few cycles after the
  // rise, so the group is stable here without a synchroniser.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_nib <= mpd_pkg::NIB_RST;
      o_tx_err <= 1'b0;
      o_tx_active <= 1'b0;
    end else begin
      o_tx_valid <= rise & mii.tx_en; // RULE14
      if (rise) begin
        o_tx_nib <= mii.txd; // RULE2
        o_tx_err <= mii.tx_er; // RULE14
        o_tx_active <= mii.tx_en; // RULE14
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive side.

  // The buffer drains one nibble per link clock, so the decoder sees it fill.
  mpd_fifo #(
    .WIDTH(mpd_pkg::RXQ_W),
    .DEPTH(mpd_pkg::RXQ_D)
  ) u_rxq (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_in_valid(i_rx_valid),
    .i_in_data({i_rx_err, i_rx_nib}),
    .o_in_ready(o_rx_ready),
    .o_out_valid(q_valid),
    .o_out_data(q_data),
    .i_out_ready(fall)
  );

  // Receive group changes only at the falling link edge, stable at the rise.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rxd_q <= mpd_pkg::NIB_RST;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
    end else if (fall) begin
      rxd_q <= q_valid ? q_data[3:0] : mpd_pkg::NIB_RST; // RULE5
      rx_dv_q <= q_valid; // RULE6
      rx_er_q <= q_valid & q_data[4]; // RULE8
    end
  end

  assign mii.rxd = rxd_q; // RULE2
  assign mii.rx_dv = rx_dv_q;
  assign mii.rx_er = rx_er_q;

  //////////////////////////////////////////////////////////////////////////////
  // Carrier sense and collision.

  // Own transmission counts toward carrier only in half duplex.
  assign want_crs = i_carrier | (~i_full_duplex & o_tx_active); // RULE11 RULE12

  // Carrier rises at once but falls only on a falling link edge.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      crs_q <= 1'b0;
    end else if (want_crs) begin
      crs_q <= 1'b1; // RULE13
    end else if (fall) begin
      crs_q <= 1'b0; // RULE13
    end
  end

  // Collision holds while both transmitting and receiving in half duplex.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      col_q <= 1'b0;
    end else begin
      col_q <= ~i_full_duplex & o_tx_active & i_carrier; // RULE9 RULE10
    end
  end

  assign mii.crs = crs_q;
  assign mii.col = col_q;
endmodule : mpd_phy

`default_nettype wire

// ---- hw/mpd_pkg.sv ----
// Shared constants for the media independent interface data path.
package mpd_pkg;

  // System clock rate and the two link clock rates.
  localparam int CLK_HZ = 125_000_000;
  localparam int LINK100_HZ = 25_000_000;
  localparam int LINK10_HZ = 2_500_000;

  // Link clock divide ratios in system cycles.
  localparam int DIV100 = CLK_HZ / LINK100_HZ;
  localparam int DIV10 = CLK_HZ / LINK10_HZ;
  localparam logic [5:0] DIV100_M1 = 6'(DIV100 - 1);
  localparam logic [5:0] DIV10_M1 = 6'(DIV10 - 1);
  localparam logic [5:0] HALF100 = 6'(DIV100 / 2);
  localparam logic [5:0] HALF10 = 6'(DIV10 / 2);

  // Nibble width and receive buffer shape.
  localparam int NIB_W = 4;
  localparam int RXQ_W = NIB_W + 1;
  localparam int RXQ_D = 8;

  // Values after reset.
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam logic [3:0] NIB_RST = 4'h0;

endpackage : mpd_pkg

// ---- hw/mpd_mii_if.sv ----
// Media independent interface wires between the transceiver and the controller.
`timescale 1ns/100ps
`default_nettype none

interface mpd_mii_if;
  // Transmit group, driven by the controller.
  logic [3:0] txd;
  logic tx_en;
  logic tx_er;
  // Clocks, driven by the transceiver.
  logic tx_clk;
  logic rx_clk;
  // Receive group and line status, driven by the transceiver.
  logic [3:0] rxd;
  logic rx_dv;
  logic rx_er;
  logic col;
  logic crs;

  modport phy (
    input txd, tx_en, tx_er,
    output tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs
  );

  modport mac (
    output txd, tx_en, tx_er,
    input tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs
  );
endinterface : mpd_mii_if

`default_nettype wire

// ---- hw/mpd_mac.sv ----
// Controller end of the interface data path.
`timescale 1ns/100ps
`default_nettype none

module mpd_mac (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Transmit nibbles from the controller core.
  input wire logic i_tx_valid,
  input wire logic [3:0] i_tx_nib,
  input wire logic i_tx_err,
  output logic o_tx_taken,
  // Receive nibbles to the controller core.
  output logic o_rx_valid,
  output logic [3:0] o_rx_nib,
  output logic o_rx_err,
  // Line status.
  output logic o_crs,
  output logic o_col,
  // Link to the transceiver.
  mpd_mii_if.mac mii
);
  logic [9:0] s1_q;
  logic [9:0] s2_q;
  logic tx_prev_q;
  logic rx_prev_q;
  logic tx_rise;
  logic rx_rise;
  logic [3:0] txd_q;
  logic tx_en_q;
  logic tx_er_q;

  // Two-stage synchroniser for everything the transceiver drives.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_q <= 10'h000;
      s2_q <= 10'h000;
    end else begin
      s1_q <= {mii.tx_clk, mii.rx_clk, mii.rxd, mii.rx_dv, mii.rx_er, mii.crs, mii.col}; // RULE10
      s2_q <= s1_q;
    end
  end

  // Edge finders on the synchronised clocks.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_prev_q <= 1'b0;
      rx_prev_q <= 1'b0;
    end else begin
      tx_prev_q <= s2_q[9];
      rx_prev_q <= s2_q[8];
    end
  end

  assign tx_rise = s2_q[9] & ~tx_prev_q;
  assign rx_rise = s2_q[8] & ~rx_prev_q;

  // Transmit group moves just after each rise; enable only with a nibble.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      txd_q <= mpd_pkg::NIB_RST;
      tx_en_q <= 1'b0;
      tx_er_q <= 1'b0;
      o_tx_taken <= 1'b0;
    end else begin
      o_tx_taken <= tx_rise & i_tx_valid;
      if (tx_rise) begin
        txd_q <= i_tx_valid ? i_tx_nib : mpd_pkg::NIB_RST; // RULE1 RULE2
        tx_en_q <= i_tx_valid; // RULE3
        tx_er_q <= i_tx_valid & i_tx_err; // RULE7
      end
    end
  end

  assign mii.txd = txd_q;
  assign mii.tx_en = tx_en_q;
  assign mii.tx_er = tx_er_q;

  // Receive group captured at the synchronised rise, delayed like the clock.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_nib <= mpd_pkg::NIB_RST;
      o_rx_err <= 1'b0;
    end else begin
      o_rx_valid <= rx_rise & s2_q[3];
      if (rx_rise) begin
        o_rx_nib <= s2_q[7:4]; // RULE2
        o_rx_err <= s2_q[2];
      end
    end
  end

  // Line status handed on from the synchroniser.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_crs <= 1'b0;
      o_col <= 1'b0;
    end else begin
      o_crs <= s2_q[1];
      o_col <= s2_q[0];
    end
  end
endmodule : mpd_mac

`default_nettype wire

// ---- bench/mpd_assertions.sv ----
// Checks on the wires between the two ends.
`timescale 1ns/100ps
`default_nettype none

module mpd_assertions (
  // Clock, reset, mode.
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_full_duplex,
  // Wires.
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic col,
  input wire logic crs
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  logic [5:0] gap_q;
  logic seen_q;
  logic clk_q;

  // Cycles since the last link clock rise; the first rise only arms it.
  always_ff @(posedge i_mclk) begin
    clk_q <= tx_clk;
    if (i_rst) begin
      gap_q <= 6'h00;
      seen_q <= 1'b0;
    end else if (tx_clk && !clk_q) begin
      gap_q <= 6'h00;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 6'h01;
    end
  end

  sequence link_rise_s;
    $rose(tx_clk);
  endsequence

  clk_period_a: assert property (link_rise_s ##0 seen_q |->
    gap_q == mpd_pkg::DIV100_M1 || gap_q == mpd_pkg::DIV10_M1)
    else $error("link clock period wrong");
  clk_pair_a: assert property (tx_clk == rx_clk)
    else $error("link clocks differ");
  hi_phase_a: assert property (link_rise_s |-> tx_clk [*2])
    else $error("link clock high phase short");
  lo_phase_a: assert property ($fell(tx_clk) |-> !tx_clk [*3])
    else $error("link clock low phase short");
  rx_sync_a: assert property ($changed({rxd, rx_dv, rx_er}) |-> $fell(rx_clk))
    else $error("receive group moved off clock");
  tx_sync_a: assert property ($changed({txd, tx_en, tx_er}) |-> gap_q <= 6'h06)
    else $error("transmit group moved late");
  col_full_a: assert property (i_full_duplex && $past(i_full_duplex) |-> !col)
    else $error("collision in full duplex");
  col_crs_a: assert property (col |-> crs && !$past(i_full_duplex))
    else $error("collision without carrier");
  crs_fall_a: assert property ($fell(crs) |-> $fell(rx_clk))
    else $error("carrier fell off clock");
endmodule : mpd_assertions

`default_nettype wire

// ---- bench/mpd_test.sv ----
// Bench joining both ends of the data path.
`timescale 1ns/100ps
`default_nettype none

module mpd_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic spd = 1'b1, fdx = 1'b0, car = 1'b0, bad_en = 1'b0;
  logic tv = 1'b0, te = 1'b0, rv = 1'b0, re = 1'b0;
  logic [3:0] tn = 4'h0, rn = 4'h0, ptn, mrn;
  logic rdy, ptv, pte, ptv_b, taken, mrv, mre, mcrs, mcol, act;
  logic col_seen = 1'b0, crs_seen = 1'b0, bad_seen = 1'b0;
  logic [4:0] txq[$], rxq[$];
  int n_errors = 0, total_checks = 0;
  mpd_mii_if mii();
  mpd_mii_if mii_b();

  // Clock.
  always #4 i_mclk = ~i_mclk;

  mpd_phy i_mpd_phy (.i_mclk, .i_rst, .i_speed100(spd), .i_full_duplex(fdx), .i_carrier(car),
    .i_rx_valid(rv), .i_rx_nib(rn), .i_rx_err(re), .o_rx_ready(rdy), .o_tx_valid(ptv),
    .o_tx_nib(ptn), .o_tx_err(pte), .o_tx_active(act), .mii(mii));
  mpd_mac i_mpd_mac (.i_mclk, .i_rst, .i_tx_valid(tv), .i_tx_nib(tn), .i_tx_err(te),
    .o_tx_taken(taken), .o_rx_valid(mrv), .o_rx_nib(mrn), .o_rx_err(mre), .o_crs(mcrs),
    .o_col(mcol), .mii(mii));
  mpd_assertions i_mpd_assertions (.i_mclk, .i_rst, .i_full_duplex(fdx), .txd(mii.txd),
    .tx_en(mii.tx_en), .tx_er(mii.tx_er), .tx_clk(mii.tx_clk), .rx_clk(mii.rx_clk),
    .rxd(mii.rxd), .rx_dv(mii.rx_dv), .rx_er(mii.rx_er), .col(mii.col), .crs(mii.crs));
  // Second transceiver faces a controller that pulses its enable off the clock.
  mpd_phy i_mpd_phy_b (.i_mclk, .i_rst, .i_speed100(spd), .i_full_duplex(fdx), .i_carrier(car),
    .i_rx_valid(1'b0), .i_rx_nib(4'h0), .i_rx_err(1'b0), .o_rx_ready(), .o_tx_valid(ptv_b),
    .o_tx_nib(), .o_tx_err(), .o_tx_active(), .mii(mii_b));
  assign mii_b.txd = 4'ha;
  assign mii_b.tx_er = 1'b0;
  assign mii_b.tx_en = bad_en;

  task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic exp_crs(input logic f, input logic c);
    return c | !f;
  endfunction : exp_crs

  // Each arriving nibble is compared with the oldest one offered.
  always @(posedge i_mclk) begin
    if (ptv === 1'b1 && !i_rst) begin
      chk("tx", txq.size() ? txq.pop_front() : 5'hx, {pte, ptn});
    end
    if (mrv === 1'b1 && !i_rst) begin
      chk("rx", rxq.size() ? rxq.pop_front() : 5'hx, {mre, mrn});
    end
    if (mcol === 1'b1) col_seen <= 1'b1;
    if (mcrs === 1'b1) crs_seen <= 1'b1;
    if (ptv_b === 1'b1) bad_seen <= 1'b1;
  end

  task automatic do_reset(input logic s);
    i_rst <= 1'b1;
    spd <= s;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask : do_reset

  task automatic drain();
    int k;
    k = 0;
    while ((txq.size() || rxq.size()) && k < 1000) begin
      @(posedge i_mclk);
      k++;
    end
    chk("drained", 5'h0, 5'(txq.size() + rxq.size()));
  endtask : drain

  // Offers are held until taken; the last nibble carries an error.
  task automatic send_tx(input int n);
    logic [4:0] v;
    int k;
    for (int i = 0; i < n; i++) begin
      v = {i == n - 1, 4'($urandom)};
      txq.push_back(v);
      tv <= 1'b1;
      {te, tn} <= v;
      k = 0;
      do begin
        @(posedge i_mclk);
        k++;
      end while (taken !== 1'b1 && k < 300);
      chk("taken", 5'h1, {4'h0, taken});
    end
    tv <= 1'b0;
    drain();
  endtask : send_tx

  // Back-to-back offers fill the buffer until it refuses.
  task automatic send_rx(input int n);
    logic [4:0] v;
    logic refused;
    refused = 1'b0;
    for (int i = 0; i < n; i++) begin
      v = 5'($urandom);
      rv <= 1'b1;
      {re, rn} <= v;
      @(posedge i_mclk);
      while (rdy !== 1'b1) begin
        refused = 1'b1;
        @(posedge i_mclk);
      end
      rxq.push_back(v);
    end
    rv <= 1'b0;
    chk("refused", 5'h1, {4'h0, refused});
    drain();
  endtask : send_rx

  task automatic line_test();
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 2; c++) begin
        fdx <= f[0];
        car <= c[0];
        repeat (110) @(posedge i_mclk);
        col_seen = 1'b0;
        crs_seen = 1'b0;
        send_tx(3);
        chk("col", {4'h0, !f[0] && c[0]}, {4'h0, col_seen});
        chk("crs", {4'h0, exp_crs(f[0], c[0])}, {4'h0, crs_seen});
      end
    end
    car <= 1'b0;
    repeat (110) @(posedge i_mclk);
    chk("crs idle", 5'h0, {4'h0, mcrs});
    chk("active idle", 5'h0, {4'h0, act});
  endtask : line_test

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Main sequence at both speeds, then the stray enable.
  initial begin
    void'($urandom(32'h4401d2a5));
    for (int s = 0; s < 2; s++) begin
      do_reset(s == 0);
      send_tx(8);
      send_rx(12);
      line_test();
      $display("Speed pass %0d done", s);
    end
    @(negedge mii_b.tx_clk);
    @(posedge i_mclk);
    bad_en <= 1'b1;
    @(posedge i_mclk);
    bad_en <= 1'b0;
    repeat (60) @(posedge i_mclk);
    chk("stray", 5'h0, {4'h0, bad_seen});
    $display("Stray enable done");
    end_sim();
  end

  // Watchdog.
  initial begin
    repeat (40000) @(posedge i_mclk);
    n_errors++;
    end_sim();
  end
endmodule : mpd_test

`default_nettype wire
